// file: include/adc_defines.svh
// register indices, field positions, reset values and timing counts of the converter control
// assumes a 200 MHz system clock and a byte-addressed bus, one register per 32-bit word
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define CONV_CONTROL_IDX  8'h1f
`define CONV_CLOCK_IDX    8'h9f
`define RESULT_HIGH_IDX   8'h1e
`define RESULT_LOW_IDX    8'h20
`define IRQ_STATUS_IDX    8'h21
`define IRQ_ENABLE_IDX    8'h22
`define IRQ_CLEAR_IDX     8'h23

// ************************************************************
// field positions
// ************************************************************
`define POWER_BIT         0
`define GO_BIT            1
`define CHAN_LSB          2
`define CHAN_MSB          5
`define REF_BIT           6
`define JUSTIFY_BIT       7
`define DIVSEL_LSB        4
`define DIVSEL_MSB        6
`define DONE_BIT          6
`define CLOCK_REG_MASK    8'h70

// ************************************************************
// reset values
// ************************************************************
`define CONTROL_RESET     8'h00
`define CLOCK_RESET       8'h00
`define IRQ_RESET         8'h00

// ************************************************************
// timing
// ************************************************************
`define CLK_FREQ_KHZ      200000
`define RC_MAX_FREQ_KHZ   500
`define RC_DIV_CYCLES     ((`CLK_FREQ_KHZ + `RC_MAX_FREQ_KHZ - 1) / `RC_MAX_FREQ_KHZ)
`define RESULT_BITS       10
// cycles a trial must have stood before its compare is read (the two sync flops, no extra settling)
`define TRIAL_AGE_MIN     2'h2

`endif

// file: include/adc_pkg.sv
// types shared by the converter control and its conversion clock generator
// uses nothing from adc_defines.svh; its state and divider encodings are literal constants
package adc_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b11,
        ST_FINISH  = 2'b10
    } conv_state_t;

    typedef enum logic [2:0]
    {
        DIV_2    = 3'b000,
        DIV_8    = 3'b001,
        DIV_32   = 3'b010,
        RC_OSC_A = 3'b011,
        DIV_4    = 3'b100,
        DIV_16   = 3'b101,
        DIV_64   = 3'b110,
        RC_OSC_B = 3'b111
    } div_code_t;

endpackage

// file: rtl/conv_clock_gen.sv
// conversion clock generator: one-cycle tick per conversion clock period
// assumes clk at 200 MHz; the internal oscillator is emulated by a slow divider of clk
`timescale 1ns/1ps
`include "adc_defines.svh"

module conv_clock_gen
#(
    parameter int RC_DIV = `RC_DIV_CYCLES
)
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              run,
    input  adc_pkg::div_code_t     divider_select,
    output logic                   tick
);
    import adc_pkg::*;

    logic [8:0] count;
    logic [8:0] next_count;
    logic [8:0] limit;
    logic       next_tick;

    // ************************************************************
    // divide ratio
    // ************************************************************
    always_comb
    begin
        unique case (divider_select)
            DIV_2:    limit = 9'h002;
            DIV_8:    limit = 9'h008;
            DIV_32:   limit = 9'h020;
            DIV_64:   limit = 9'h040;
            DIV_4:    limit = 9'h004;
            DIV_16:   limit = 9'h010;
            RC_OSC_A,
            RC_OSC_B: limit = RC_DIV[8:0];
        endcase
    end

    // ************************************************************
    // prescaler
    // ************************************************************
    // >= rather than == so that a ratio change mid-count cannot overrun
    always_comb
    begin
        next_tick  = 1'b0;
        next_count = count + 9'h001;
        if (!run)
        begin
            next_count = 9'h000;
        end
        else if (count >= limit - 9'h001)
        begin
            next_count = 9'h000;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count <= 9'h000;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule

// file: rtl/adc_conversion_control.sv
// converter control: registers, successive-approximation sequencer and interrupt
// assumes an Avalon-MM master on clk and a converter core with a trial dac and comparator
//
// Function
// - channel_select bits 5:2 route input channel 0 to 11 to the converter.
// - writing go bit 1 starts a conversion; reading 1 means busy.
// - go bit clears by itself when the conversion finishes.
// - converter powered only while conv_power_on bit 0 is set.
// - divider codes 000, 001, 010, 110 give clock over 2, 8, 32, 64.
// - clock register bit 7 and bits 3:0 read zero, writes ignored.
// - ref_select bit 6 chooses the converter voltage reference.
// - result_justify bit 7 sets right or left justification of the result pair.
// - completion raises the converter interrupt when enabled.
// - result pair loads in the same cycle that the go bit clears.
// - reset powers down and aborts, leaving the result pair unchanged.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_conversion_control
#(
    parameter int RC_DIV = `RC_DIV_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             irq,
    output logic             conv_power,
    output logic [3:0]       channel_route,
    output logic             ref_sel,
    output logic             sample_hold,
    output logic [9:0]       trial_code,
    input  wire logic        comp_above
);
    import adc_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [7:0]  control;
    logic [7:0]  next_control;
    logic [7:0]  clock_cfg;
    logic [7:0]  next_clock_cfg;
    logic        go;
    logic        next_go;
    logic [7:0]  result_high;
    logic [7:0]  next_result_high;
    logic [7:0]  result_low;
    logic [7:0]  next_result_low;
    logic        done_flag;
    logic        next_done_flag;
    logic        done_irq_en;
    logic        next_done_irq_en;
    logic        ack;
    logic        next_ack;
    logic [31:0] next_readdata;
    logic [7:0]  index;
    logic        wr_take;
    logic [7:0]  wbyte;
    conv_state_t state;
    conv_state_t next_state;
    logic [9:0]  sar;
    logic [9:0]  next_sar;
    logic [3:0]  bit_idx;
    logic [3:0]  next_bit_idx;
    logic        finish;
    logic        abort;
    logic        tick;
    logic        comp_meta;
    logic        comp_sync;
    logic [1:0]  age;
    logic [1:0]  next_age;

    // ************************************************************
    // comparator synchroniser
    // ************************************************************
    // a compare seen here is two cycles old, so a trial must stand that long before it is judged
    always_ff @(posedge clk)
    begin
        comp_meta <= comp_above;
        comp_sync <= comp_meta;
    end

    // ************************************************************
    // conversion clock
    // ************************************************************
    conv_clock_gen
    #(
        .RC_DIV         (RC_DIV)
    )
    u_clock_gen
    (
        .clk            (clk),
        .srst           (srst),
        .run            (control[`POWER_BIT]),
        .divider_select (div_code_t'(clock_cfg[`DIVSEL_MSB:`DIVSEL_LSB])),
        .tick           (tick)
    );

    // ************************************************************
    // bus slave
    // ************************************************************
    // one wait state: the request cycle latches read data, the next cycle answers
    assign index       = address[9:2];
    assign waitrequest = (read | write) & ~ack;
    assign wr_take     = write & ack & byteenable[0];
    assign wbyte       = writedata[7:0];

    always_comb
    begin
        next_ack      = (read | write) & ~ack;
        next_readdata = readdata;
        if (read & ~ack)
        begin
            unique case (index)
                `CONV_CONTROL_IDX: next_readdata = {24'h000000, control[7:2], go, control[`POWER_BIT]};
                `CONV_CLOCK_IDX:   next_readdata = {24'h000000, clock_cfg & `CLOCK_REG_MASK};
                `RESULT_HIGH_IDX:  next_readdata = {24'h000000, result_high};
                `RESULT_LOW_IDX:   next_readdata = {24'h000000, result_low};
                `IRQ_STATUS_IDX:   next_readdata = {24'h000000, 8'(32'(done_flag) << `DONE_BIT)};
                `IRQ_ENABLE_IDX:   next_readdata = {24'h000000, 8'(32'(done_irq_en) << `DONE_BIT)};
                default:           next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ack      <= 1'b0;
            readdata <= 32'h00000000;
        end
        else
        begin
            ack      <= next_ack;
            readdata <= next_readdata;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_comb
    begin
        next_control   = control;
        next_clock_cfg = clock_cfg;
        if (wr_take && index == `CONV_CONTROL_IDX)
        begin
            next_control = wbyte;
        end
        if (wr_take && index == `CONV_CLOCK_IDX)
        begin
            next_clock_cfg = wbyte & `CLOCK_REG_MASK;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            control   <= `CONTROL_RESET;
            clock_cfg <= `CLOCK_RESET;
        end
        else
        begin
            control   <= next_control;
            clock_cfg <= next_clock_cfg;
        end
    end

    assign conv_power    = control[`POWER_BIT];
    assign channel_route = control[`CHAN_MSB:`CHAN_LSB];
    assign ref_sel       = control[`REF_BIT];

    // ************************************************************
    // go flag
    // ************************************************************
    // writing zero while busy, or dropping power, aborts without touching the result, except in the ST_FINISH cycle, where the result still loads
    assign finish = (state == ST_FINISH);
    assign abort  = ~control[`POWER_BIT] | (wr_take && index == `CONV_CONTROL_IDX && !wbyte[`GO_BIT]);

    always_comb
    begin
        next_go = go;
        if (finish || abort)
        begin
            next_go = 1'b0;
        end
        else if (wr_take && index == `CONV_CONTROL_IDX && wbyte[`GO_BIT] && wbyte[`POWER_BIT])
        begin
            next_go = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            go <= 1'b0;
        end
        else
        begin
            go <= next_go;
        end
    end

    // ************************************************************
    // successive-approximation sequencer
    // ************************************************************
    always_comb
    begin
        next_state   = state;
        next_sar     = sar;
        next_bit_idx = bit_idx;
        next_age     = (age == 2'h3) ? age : age + 2'h1;
        if (abort && state != ST_FINISH)
        begin
            next_state = ST_IDLE;
            next_sar   = 10'h000;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        next_state = ST_SAMPLE;
                    end
                end
                ST_SAMPLE:
                begin
                    if (tick)
                    begin
                        next_state   = ST_CONVERT;
                        next_sar     = 10'h200;
                        next_bit_idx = 4'h9;
                    end
                end
                ST_CONVERT:
                begin
                    // at the fastest ratio a bit takes two ticks: speed traded for a settled compare
                    if (tick && age >= `TRIAL_AGE_MIN)
                    begin
                        next_sar[bit_idx] = comp_sync;
                        if (bit_idx == 4'h0)
                        begin
                            next_state = ST_FINISH;
                        end
                        else
                        begin
                            next_sar[bit_idx - 4'h1] = 1'b1;
                            next_bit_idx             = bit_idx - 4'h1;
                        end
                    end
                end
                ST_FINISH:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
        if (next_sar != sar)
        begin
            next_age = 2'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state   <= ST_IDLE;
            sar     <= 10'h000;
            bit_idx <= 4'h0;
            age     <= 2'h0;
        end
        else
        begin
            state   <= next_state;
            sar     <= next_sar;
            bit_idx <= next_bit_idx;
            age     <= next_age;
        end
    end

    assign sample_hold = (state == ST_CONVERT);
    assign trial_code  = sar;

    // ************************************************************
    // result pair
    // ************************************************************
    // no reset on purpose: the last result survives a device reset
    always_comb
    begin
        next_result_high = result_high;
        next_result_low  = result_low;
        if (finish)
        begin
            if (control[`JUSTIFY_BIT])
            begin
                next_result_high = {6'h00, sar[9:8]};
                next_result_low  = sar[7:0];
            end
            else
            begin
                next_result_high = sar[9:2];
                next_result_low  = {sar[1:0], 6'h00};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        result_high <= next_result_high;
        result_low  <= next_result_low;
    end

    // ************************************************************
    // interrupt
    // ************************************************************
    // a completion in the clearing cycle wins, so no event is lost
    always_comb
    begin
        next_done_flag   = done_flag;
        next_done_irq_en = done_irq_en;
        if (wr_take && index == `IRQ_CLEAR_IDX && wbyte[`DONE_BIT])
        begin
            next_done_flag = 1'b0;
        end
        if (finish)
        begin
            next_done_flag = 1'b1;
        end
        if (wr_take && index == `IRQ_ENABLE_IDX)
        begin
            next_done_irq_en = wbyte[`DONE_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            done_flag   <= `IRQ_RESET == 8'h00 ? 1'b0 : 1'b1;
            done_irq_en <= 1'b0;
        end
        else
        begin
            done_flag   <= next_done_flag;
            done_irq_en <= next_done_irq_en;
        end
    end

    assign irq = done_flag & done_irq_en;

endmodule

// file: verif/adc_conversion_control_checker.sv
// checker: bus timing, port relations and conversion sequence of the converter control
// assumes only the top module's ports; attached by the bind after the module
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_conversion_control_checker
#(
    parameter int RC_DIV = `RC_DIV_CYCLES
)
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq,
    input wire logic        conv_power,
    input wire logic [3:0]  channel_route,
    input wire logic        ref_sel,
    input wire logic        sample_hold,
    input wire logic [9:0]  trial_code,
    input wire logic        comp_above
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ************************************************************
    // properties
    // ************************************************************
    property p_one_wait;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    property p_read_bits;
        read && !waitrequest |-> readdata[31:8] == 24'h0 &&
            (address[9:2] != `CONV_CLOCK_IDX || (readdata[7:0] & ~`CLOCK_REG_MASK) == 8'h00);
    endproperty
    property p_ctrl_ports;
        logic [7:0] v;
        (write && !waitrequest && byteenable[0] && address[9:2] == `CONV_CONTROL_IDX, v = writedata[7:0])
            |=> channel_route == v[5:2] && ref_sel == v[6] && conv_power == v[0];
    endproperty
    property p_reset_off;
        $fell(srst) |-> !conv_power && !sample_hold && !irq;
    endproperty
    property p_power_off;
        !conv_power [*2] |-> !sample_hold;
    endproperty
    property p_start_trial;
        $rose(sample_hold) |-> trial_code == 10'h200;
    endproperty
    property p_hold_min;
        $rose(sample_hold) |-> sample_hold [*8];
    endproperty
    property p_irq_cause;
        $rose(irq) |-> $past(sample_hold) || $past(sample_hold, 2) || $past(write);
    endproperty

    // ************************************************************
    // assertions and covers
    // ************************************************************
    a_one_wait: assert property (p_one_wait) else $error("access longer than one wait state");
    a_read_bits: assert property (p_read_bits) else $error("unused read bits not zero");
    a_ctrl_ports: assert property (p_ctrl_ports) else $error("control write not on ports");
    a_reset_off: assert property (p_reset_off) else $error("reset left converter active");
    a_power_off: assert property (p_power_off) else $error("converting while unpowered");
    a_start_trial: assert property (p_start_trial) else $error("first trial not midscale");
    a_hold_min: assert property (p_hold_min) else $error("conversion too short");
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
    c_irq: cover property ($rose(irq));
    c_done: cover property ($fell(sample_hold));
    c_clock_read: cover property (read && !waitrequest && address[9:2] == `CONV_CLOCK_IDX);
endmodule

bind adc_conversion_control adc_conversion_control_checker #(.RC_DIV(RC_DIV)) u_adc_conversion_control_checker
(
    .clk, .srst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .irq, .conv_power, .channel_route, .ref_sel, .sample_hold, .trial_code, .comp_above
);

// file: verif/conv_core_model.sv
// far side model: analog inputs, reference and comparator of the converter core
// assumes the bench loads level[] before each conversion
`timescale 1ns/1ps

module conv_core_model
(
    input  wire logic       clk,
    input  wire logic       conv_power,
    input  wire logic [3:0] channel_route,
    input  wire logic       ref_sel,
    input  wire logic [9:0] trial_code,
    output logic            comp_above
);
    // analog inputs are only read, never driven back
    logic [9:0] level [0:11] = '{default: 10'h000};
    logic [9:0] vin;
    logic       idle_toggle = 1'b0;

    // unpowered comparator output is garbage, so it toggles rather than holding a value
    always @(posedge clk) idle_toggle <= ~idle_toggle;

    always_comb
    begin
        vin = (channel_route < 4'd12) ? level[channel_route] : 10'h000;
        if (ref_sel)
            vin = vin >> 1;
        comp_above = conv_power ? (vin >= trial_code) : idle_toggle;
    end
endmodule

// file: verif/adc_conversion_control_tb.sv
// testbench: register access, conversions at every clock code, abort and reset
// assumes the converter core model and the checker bound to the design
`timescale 1ns/1ps
`include "adc_defines.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module adc_conversion_control_tb;
    import adc_pkg::*;
    localparam int RC_TB = 12;  // shortened oscillator divider, distinct from every other ratio
    logic        clk, srst, read, write, irq, conv_power, ref_sel, sample_hold, comp_above, waitrequest;
    logic [9:0]  address, trial_code;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable, channel_route;
    logic [7:0]  last_hi, last_lo;
    int          fails, check_count;
    int          exp_q[$];
    int          tbl[8] = '{2, 8, 32, RC_TB, 4, 16, 64, RC_TB};

    adc_conversion_control #(.RC_DIV(RC_TB)) u_adc_conversion_control
    (
        .clk(clk), .srst(srst), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .conv_power(conv_power), .channel_route(channel_route), .ref_sel(ref_sel),
        .sample_hold(sample_hold), .trial_code(trial_code), .comp_above(comp_above)
    );
    conv_core_model u_conv_core_model
    (
        .clk(clk), .conv_power(conv_power), .channel_route(channel_route), .ref_sel(ref_sel),
        .trial_code(trial_code), .comp_above(comp_above)
    );

    always #2.5 clk = ~clk;

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge; read data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] rq);
        int   n;
        n = 0;
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 50)
            begin
                fails++;
                print_verdict();
            end
        end while (waitrequest !== 1'b0);
        rq = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask

    // ************************************************************
    // one conversion against the bench model
    // ************************************************************
    task automatic convert(input logic [2:0] code, input int t);
        logic [3:0] ch;
        logic [9:0] r;
        logic       just, rf, ien;
        int         cyc, hl, tb;
        ch = 4'($urandom_range(11));
        {just, rf, ien} = 3'($urandom);
        u_conv_core_model.level[ch] = 10'($urandom);
        r = rf ? u_conv_core_model.level[ch] >> 1 : u_conv_core_model.level[ch];
        exp_q.push_back(just ? {6'h00, r} : {r, 6'h00});
        tb = (`TRIAL_AGE_MIN + t) / t * t;
        wr(`CONV_CLOCK_IDX, {1'b1, code, 4'hf});
        bus(1'b0, `CONV_CLOCK_IDX, 8'h00, q);
        `CHK("clock reg", {1'b0, code, 4'h0}, q[7:0])
        wr(`IRQ_CLEAR_IDX, 8'h40);
        wr(`IRQ_ENABLE_IDX, {1'b0, ien, 6'h00});
        wr(`CONV_CONTROL_IDX, {just, rf, ch, 2'b01});
        `CHK("channel", ch, channel_route)
        `CHK("reference", rf, ref_sel)
        repeat (40) @(posedge clk);
        wr(`CONV_CONTROL_IDX, {just, rf, ch, 2'b11});
        cyc = 0;
        do
        begin
            bus(1'b0, `CONV_CONTROL_IDX, 8'h00, q);
            cyc += 3;
        end while (q[1] === 1'b1 && cyc < 2000);
        `CHK("control after done", {just, rf, ch, 2'b01}, q[7:0])
        `CHK("duration ok", 1'b1, 1'(cyc >= 10 * t && cyc <= 12 * tb + 16))
        `CHK("irq", ien, irq)
        bus(1'b0, `IRQ_STATUS_IDX, 8'h00, q);
        `CHK("status", 8'h40, q[7:0])
        hl = exp_q.pop_front();
        last_hi = hl[15:8];
        last_lo = hl[7:0];
        bus(1'b0, `RESULT_HIGH_IDX, 8'h00, q);
        `CHK("result high", last_hi, q[7:0])
        bus(1'b0, `RESULT_LOW_IDX, 8'h00, q);
        `CHK("result low", last_lo, q[7:0])
        wr(`IRQ_CLEAR_IDX, 8'h40);
        `CHK("irq cleared", 1'b0, irq)
        repeat (2 * t) @(posedge clk);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        {read, write, address, writedata} = '0;
        byteenable = 4'hf;
        fails = 0;
        check_count = 0;
        void'($urandom(32'h62c2cbef));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        bus(1'b0, `CONV_CONTROL_IDX, 8'h00, q);
        `CHK("control reset", 32'h0, q)
        wr(8'h00, 8'hff);
        bus(1'b0, 8'h00, 8'h00, q);
        `CHK("unmapped", 32'h0, q)
        byteenable <= 4'h0;
        wr(`CONV_CONTROL_IDX, 8'h01);
        byteenable <= 4'hf;
        `CHK("power unstrobed", 1'b0, conv_power)
        wr(`CONV_CONTROL_IDX, 8'h02);
        bus(1'b0, `CONV_CONTROL_IDX, 8'h00, q);
        `CHK("go unpowered", 8'h00, q[7:0])
        for (int i = 0; i < 16; i++)
            convert(3'(i), tbl[i % 8]);
        // abort by clearing go mid-conversion: no flag, result untouched
        wr(`CONV_CONTROL_IDX, 8'h03);
        repeat (100) @(posedge clk);
        wr(`CONV_CONTROL_IDX, 8'h01);
        bus(1'b0, `IRQ_STATUS_IDX, 8'h00, q);
        `CHK("abort status", 8'h00, q[7:0])
        wr(`CONV_CONTROL_IDX, 8'h03);
        repeat (100) @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("reset power", 1'b0, conv_power)
        bus(1'b0, `CONV_CONTROL_IDX, 8'h00, q);
        `CHK("reset control", 8'h00, q[7:0])
        bus(1'b0, `RESULT_HIGH_IDX, 8'h00, q);
        `CHK("kept high", last_hi, q[7:0])
        bus(1'b0, `RESULT_LOW_IDX, 8'h00, q);
        `CHK("kept low", last_lo, q[7:0])
        print_verdict();
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        fails++;
        print_verdict();
    end
endmodule
